/* File: verilog/mps_defines.svh */
/*
 * constants of the mode-parameter list checker: register map, field
 * positions, reset values, page table and sense codes.
 * assumes it is included by bare name from the package and the design.
 */
`ifndef MPS_DEFINES_SVH
`define MPS_DEFINES_SVH

// ------------------------------------------------------------
// register map
// ------------------------------------------------------------
`define MPS_A_CTRL 8'h00
`define MPS_A_LEN 8'h04
`define MPS_A_STAT 8'h08
`define MPS_A_BLEN 8'h0C
`define MPS_A_BCNT 8'h10
`define MPS_C_START 0
`define MPS_C_STRICT 1
`define MPS_C_ROUND 2
`define MPS_C_SAVE 3
`define MPS_C_CAP 4
`define MPS_C_MIN256 5
`define MPS_S_UA 3
`define MPS_RESP_OK 2'h0
`define MPS_RESP_DEC 2'h3

// ------------------------------------------------------------
// list layout and values
// ------------------------------------------------------------
`define MPS_HDR_LAST 3'h3
`define MPS_BD_LAST 3'h7
`define MPS_BD_LEN 8'h08
`define MPS_MEDIUM 8'h00
`define MPS_BLEN_MIN 24'h0000B4
`define MPS_BLEN_MIN256 24'h000100
`define MPS_BLEN_MAX 24'h001000
`define MPS_BLEN_RST 24'h000200
`define MPS_CNT_DEFAULT 32'hFFFFFFFF
`define MPS_FIX_BYTES 8'h02

// ------------------------------------------------------------
// supported pages: code, reported length, base in storage
// ------------------------------------------------------------
`define MPS_MEM_BYTES 48
`define MPS_PG_A 6'h01
`define MPS_PG_A_LEN 8'h0A
`define MPS_PG_A_BASE 6'h00
`define MPS_PG_B 6'h08
`define MPS_PG_B_LEN 8'h12
`define MPS_PG_B_BASE 6'h0A
`define MPS_PG_C 6'h0A
`define MPS_PG_C_LEN 8'h0A
`define MPS_PG_C_BASE 6'h1C
`define MPS_PG_D 6'h1C
`define MPS_PG_D_LEN 8'h0A
`define MPS_PG_D_BASE 6'h26

// ------------------------------------------------------------
// sense answers
// ------------------------------------------------------------
`define MPS_KEY_GOOD 4'h0
`define MPS_KEY_RECOVERED 4'h1
`define MPS_KEY_ILLEGAL 4'h5
`define MPS_ASC_NONE 8'h00
`define MPS_ASC_BAD_FIELD 8'h26
`define MPS_ASC_ROUNDED 8'h37
`endif

/* File: verilog/mps_pkg.sv */
/*
 * types of the mode-parameter list checker.
 * assumes mps_defines.svh is on the include path.
 */
`include "mps_defines.svh"
package mps_pkg;
    typedef enum logic [3:0] {
        MPS_IDLE = 4'h0,
        MPS_HDR = 4'h1,
        MPS_DESC = 4'h2,
        MPS_PGC = 4'h3,
        MPS_PGL = 4'h4,
        MPS_PGB = 4'h5,
        MPS_SKIP = 4'h6,
        MPS_EVAL = 4'h7,
        MPS_SAVE = 4'h8
    } mps_state_e;

    typedef struct packed {
        logic awvalid;
        logic [7:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [7:0] araddr;
        logic rready;
    } mps_axi_req_s;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } mps_axi_rsp_s;

    typedef struct packed {
        logic done;
        logic check;
        logic rounded;
        logic [3:0] sense_key;
        logic [7:0] asc;
    } mps_result_s;
endpackage

/* File: verilog/mps_checker.sv */
/*
 * mode-parameter list checker: takes the data-out byte stream of a
 * six-byte mode-setting command, checks it whole, then commits or
 * rejects it atomically. registers over axi4-lite.
 * assumes the byte stream and save handshake are on clk.
 */
// The implementer's own choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "mps_defines.svh"
module mps_checker #(
    parameter logic [31:0] PHYS_MAX_BLOCKS = 32'h00800000,
    parameter logic [31:0] DEF_BLOCKS = 32'h00400000
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire mps_pkg::mps_axi_req_s axi_req,
    output mps_pkg::mps_axi_rsp_s axi_rsp,
    input wire logic dout_valid,
    input wire logic [7:0] dout_data,
    output logic dout_ready,
    output mps_pkg::mps_result_s result,
    output logic save_req,
    input wire logic save_ack,
    output logic ua_event
);
    import mps_pkg::*;

    // ------------------------------------------------------------
    // decoding helpers
    // ------------------------------------------------------------
    function automatic logic reg_hit(input logic [7:0] a);
        reg_hit = (a == `MPS_A_CTRL) || (a == `MPS_A_LEN) || (a == `MPS_A_STAT)
            || (a == `MPS_A_BLEN) || (a == `MPS_A_BCNT);
    endfunction

    function automatic logic [7:0] pg_rlen(input logic [5:0] c);
        case (c)
            `MPS_PG_A: pg_rlen = `MPS_PG_A_LEN;
            `MPS_PG_B: pg_rlen = `MPS_PG_B_LEN;
            `MPS_PG_C: pg_rlen = `MPS_PG_C_LEN;
            `MPS_PG_D: pg_rlen = `MPS_PG_D_LEN;
            default: pg_rlen = 8'h00;
        endcase
    endfunction

    function automatic logic [5:0] pg_base(input logic [5:0] c);
        case (c)
            `MPS_PG_B: pg_base = `MPS_PG_B_BASE;
            `MPS_PG_C: pg_base = `MPS_PG_C_BASE;
            `MPS_PG_D: pg_base = `MPS_PG_D_BASE;
            default: pg_base = `MPS_PG_A_BASE;
        endcase
    endfunction

    // leading parameter bytes of each page are fixed, the rest changeable
    function automatic logic [7:0] chg_mask(input logic [7:0] i);
        chg_mask = (i < `MPS_FIX_BYTES) ? 8'h00 : 8'hFF;
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    mps_state_e state, next_state;
    logic aw_got, w_got;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic [5:0] ctrl;
    logic [7:0] plen;
    logic ua_pend;
    logic [7:0] left, idx, pg_left;
    logic [5:0] pg_code;
    logic bd_on, err, chg, rnd, bcnt_set;
    logic [31:0] bd_cnt, blk_cnt;
    logic [23:0] bd_len, blk_len;
    logic [7:0] cur_mem [`MPS_MEM_BYTES];
    logic [7:0] nxt_mem [`MPS_MEM_BYTES];
    logic [23:0] next_blen;
    logic [31:0] next_cnt;
    logic eval_err, eval_rnd;
    logic [31:0] rd_mux;

    wire aw_hs = axi_req.awvalid && axi_rsp.awready;
    wire w_hs = axi_req.wvalid && axi_rsp.wready;
    wire wr_go = aw_got && w_got && !axi_rsp.bvalid;
    wire wr_lane0 = wr_go && w_strb[0];
    wire busy = (state != MPS_IDLE);
    wire start_go = wr_lane0 && (aw_addr == `MPS_A_CTRL) && w_data[`MPS_C_START] && !busy;
    wire ua_clr = wr_lane0 && (aw_addr == `MPS_A_STAT) && w_data[`MPS_S_UA];
    wire take = dout_valid && dout_ready;
    wire last = (left == 8'h01);
    wire strict = ctrl[`MPS_C_STRICT];
    wire [7:0] rlen = pg_rlen(pg_code);
    wire [5:0] addr = pg_base(pg_code) + idx[5:0];
    wire [7:0] mask = chg_mask(idx);
    wire [7:0] cur_b = cur_mem[addr];
    wire clean_end = (state == MPS_HDR && idx[2:0] == `MPS_HDR_LAST)
        || (state == MPS_DESC && idx[2:0] == `MPS_BD_LAST)
        || ((state == MPS_PGB || state == MPS_SKIP) && pg_left == 8'h01);

    // ------------------------------------------------------------
    // axi4-lite write channel
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            aw_got <= 1'b0;
            w_got <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
        end else begin
            if (aw_hs) begin
                aw_got <= 1'b1;
                aw_addr <= axi_req.awaddr;
            end else if (wr_go) begin
                aw_got <= 1'b0;
            end
            if (w_hs) begin
                w_got <= 1'b1;
                w_data <= axi_req.wdata;
                w_strb <= axi_req.wstrb;
            end else if (wr_go) begin
                w_got <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            axi_rsp.awready <= 1'b0;
            axi_rsp.wready <= 1'b0;
            axi_rsp.bvalid <= 1'b0;
            axi_rsp.bresp <= `MPS_RESP_OK;
        end else begin
            axi_rsp.awready <= !(aw_hs || (aw_got && !wr_go));
            axi_rsp.wready <= !(w_hs || (w_got && !wr_go));
            if (wr_go) begin
                axi_rsp.bvalid <= 1'b1;
                axi_rsp.bresp <= reg_hit(aw_addr) ? `MPS_RESP_OK : `MPS_RESP_DEC;
            end else if (axi_req.bready) begin
                axi_rsp.bvalid <= 1'b0;
            end
        end
    end

    // configuration is frozen while a list is being checked
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl <= 6'h00;
            plen <= 8'h00;
        end else if (wr_lane0 && !busy) begin
            if (aw_addr == `MPS_A_CTRL) begin
                ctrl <= w_data[5:0];
            end
            if (aw_addr == `MPS_A_LEN) begin
                plen <= w_data[7:0];
            end
        end
    end

    // ------------------------------------------------------------
    // axi4-lite read channel
    // ------------------------------------------------------------
    always_comb begin
        case (axi_req.araddr)
            `MPS_A_CTRL: rd_mux = {26'h0, ctrl};
            `MPS_A_LEN: rd_mux = {24'h0, plen};
            `MPS_A_STAT: rd_mux = {8'h00, result.asc, 4'h0, result.sense_key, 4'h0,
                ua_pend, result.rounded, result.check, busy};
            `MPS_A_BLEN: rd_mux = {8'h00, blk_len};
            `MPS_A_BCNT: rd_mux = blk_cnt;
            default: rd_mux = 32'h00000000;
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            axi_rsp.arready <= 1'b0;
            axi_rsp.rvalid <= 1'b0;
            axi_rsp.rdata <= 32'h00000000;
            axi_rsp.rresp <= `MPS_RESP_OK;
        end else if (axi_req.arvalid && axi_rsp.arready) begin
            axi_rsp.arready <= 1'b0;
            axi_rsp.rvalid <= 1'b1;
            axi_rsp.rdata <= rd_mux;
            axi_rsp.rresp <= reg_hit(axi_req.araddr) ? `MPS_RESP_OK : `MPS_RESP_DEC;
        end else if (axi_rsp.rvalid) begin
            axi_rsp.arready <= axi_req.rready;
            axi_rsp.rvalid <= !axi_req.rready;
        end else begin
            axi_rsp.arready <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // parse sequencing
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        case (state)
            MPS_IDLE: begin
                if (start_go) begin
                    next_state = (plen == 8'h00) ? MPS_EVAL : MPS_HDR;
                end
            end
            MPS_HDR, MPS_DESC, MPS_PGC, MPS_PGL, MPS_PGB, MPS_SKIP: begin
                if (take && last) begin
                    next_state = MPS_EVAL;
                end else if (take) begin
                    case (state)
                        MPS_HDR: begin
                            if (idx[2:0] == `MPS_HDR_LAST) begin
                                next_state = (dout_data == `MPS_BD_LEN) ? MPS_DESC : MPS_PGC;
                            end
                        end
                        MPS_DESC: begin
                            if (idx[2:0] == `MPS_BD_LAST) begin
                                next_state = MPS_PGC;
                            end
                        end
                        MPS_PGC: next_state = MPS_PGL;
                        MPS_PGL: begin
                            if (dout_data == 8'h00) begin
                                next_state = MPS_PGC;
                            end else if (rlen != 8'h00 && dout_data == rlen) begin
                                next_state = MPS_PGB;
                            end else begin
                                next_state = MPS_SKIP;
                            end
                        end
                        default: begin
                            if (pg_left == 8'h01) begin
                                next_state = MPS_PGC;
                            end
                        end
                    endcase
                end
            end
            MPS_EVAL: begin
                next_state = (!eval_err && ctrl[`MPS_C_SAVE]) ? MPS_SAVE : MPS_IDLE;
            end
            MPS_SAVE: begin
                if (save_ack) begin
                    next_state = MPS_IDLE;
                end
            end
            default: next_state = MPS_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= MPS_IDLE;
            dout_ready <= 1'b0;
        end else begin
            state <= next_state;
            dout_ready <= (next_state inside {MPS_HDR, MPS_DESC, MPS_PGC, MPS_PGL,
                MPS_PGB, MPS_SKIP});
        end
    end

    // ------------------------------------------------------------
    // per-byte checks and staging
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            left <= 8'h00;
            idx <= 8'h00;
            pg_left <= 8'h00;
            pg_code <= 6'h00;
            bd_on <= 1'b0;
            err <= 1'b0;
            chg <= 1'b0;
            bd_cnt <= 32'h00000000;
            bd_len <= 24'h000000;
            for (int i = 0; i < `MPS_MEM_BYTES; i++) begin
                nxt_mem[i] <= 8'h00;
            end
        end else if (start_go) begin
            left <= plen;
            idx <= 8'h00;
            bd_on <= 1'b0;
            err <= 1'b0;
            chg <= 1'b0;
            nxt_mem <= cur_mem;
        end else if (take) begin
            left <= left - 8'h01;
            idx <= idx + 8'h01;
            if (last && !clean_end) begin
                err <= 1'b1;
            end
            case (state)
                MPS_HDR: begin
                    if (idx[1:0] == 2'h1 && dout_data != `MPS_MEDIUM) begin
                        err <= 1'b1;
                    end
                    if ((idx[1:0] == 2'h0 || idx[1:0] == 2'h2) && dout_data != 8'h00) begin
                        err <= 1'b1;
                    end
                    if (idx[2:0] == `MPS_HDR_LAST) begin
                        idx <= 8'h00;
                        bd_on <= (dout_data == `MPS_BD_LEN);
                        if (dout_data != `MPS_BD_LEN && dout_data != 8'h00) begin
                            err <= 1'b1;
                        end
                    end
                end
                MPS_DESC: begin
                    if (idx[2:0] < 3'h4) begin
                        bd_cnt <= {bd_cnt[23:0], dout_data};
                        if (!ctrl[`MPS_C_CAP] && dout_data != 8'h00) begin
                            err <= 1'b1;
                        end
                    end else if (idx[2:0] == 3'h4) begin
                        if (dout_data != 8'h00) begin
                            err <= 1'b1;
                        end
                    end else begin
                        bd_len <= {bd_len[15:0], dout_data};
                    end
                end
                MPS_PGC: begin
                    pg_code <= dout_data[5:0];
                    if (dout_data[7:6] != 2'h0) begin
                        err <= 1'b1;
                    end
                    if (pg_rlen(dout_data[5:0]) == 8'h00 && strict) begin
                        err <= 1'b1;
                    end
                end
                MPS_PGL: begin
                    idx <= 8'h00;
                    pg_left <= dout_data;
                    if (rlen != 8'h00 && dout_data != rlen) begin
                        err <= 1'b1;
                    end
                end
                MPS_PGB: begin
                    pg_left <= pg_left - 8'h01;
                    if (((dout_data ^ cur_b) & ~mask) != 8'h00 && strict) begin
                        err <= 1'b1;
                    end
                    nxt_mem[addr] <= (dout_data & mask) | (cur_b & ~mask);
                    if (((dout_data ^ cur_b) & mask) != 8'h00) begin
                        chg <= 1'b1;
                    end
                end
                MPS_SKIP: pg_left <= pg_left - 8'h01;
                default: pg_left <= pg_left;
            endcase
        end
    end

    // ------------------------------------------------------------
    // descriptor evaluation
    // ------------------------------------------------------------
    always_comb begin
        logic [23:0] lo;
        lo = ctrl[`MPS_C_MIN256] ? `MPS_BLEN_MIN256 : `MPS_BLEN_MIN;
        next_blen = blk_len;
        next_cnt = blk_cnt;
        eval_rnd = 1'b0;
        eval_err = err;
        if (bd_on) begin
            if (bd_len < lo) begin
                next_blen = lo;
                eval_rnd = 1'b1;
            end else if (bd_len > `MPS_BLEN_MAX) begin
                next_blen = `MPS_BLEN_MAX;
                eval_rnd = 1'b1;
            end else begin
                next_blen = {bd_len[23:1], 1'b0};
                eval_rnd = bd_len[0];
            end
            if (bd_cnt == `MPS_CNT_DEFAULT) begin
                next_cnt = DEF_BLOCKS;
            end else if (bd_cnt > PHYS_MAX_BLOCKS) begin
                eval_err = 1'b1;
            end else if (bd_cnt != 32'h00000000) begin
                next_cnt = bd_cnt;
            end else if (next_blen != blk_len) begin
                next_cnt = DEF_BLOCKS;
            end
        end
    end

    // ------------------------------------------------------------
    // commit and completion
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            blk_len <= `MPS_BLEN_RST;
            blk_cnt <= DEF_BLOCKS;
            bcnt_set <= 1'b0;
            rnd <= 1'b0;
            for (int i = 0; i < `MPS_MEM_BYTES; i++) begin
                cur_mem[i] <= 8'h00;
            end
        end else if (state == MPS_EVAL && !eval_err) begin
            cur_mem <= nxt_mem;
            blk_len <= next_blen;
            blk_cnt <= next_cnt;
            bcnt_set <= chg || (next_blen != blk_len) || (next_cnt != blk_cnt);
            rnd <= eval_rnd;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            result <= '0;
            save_req <= 1'b0;
        end else begin
            result.done <= 1'b0;
            if (start_go) begin
                result <= '0;
            end else if (state == MPS_EVAL && eval_err) begin
                result.done <= 1'b1;
                result.check <= 1'b1;
                result.sense_key <= `MPS_KEY_ILLEGAL;
                result.asc <= `MPS_ASC_BAD_FIELD;
            end else if (state == MPS_EVAL && ctrl[`MPS_C_SAVE]) begin
                save_req <= 1'b1;
            end else if ((state == MPS_EVAL) || (state == MPS_SAVE && save_ack)) begin
                save_req <= 1'b0;
                result.done <= 1'b1;
                result.rounded <= rnd || (state == MPS_EVAL && eval_rnd);
                if (ctrl[`MPS_C_ROUND] && (rnd || (state == MPS_EVAL && eval_rnd))) begin
                    result.check <= 1'b1;
                    result.sense_key <= `MPS_KEY_RECOVERED;
                    result.asc <= `MPS_ASC_ROUNDED;
                end
            end
        end
    end

    // unit attention for other initiators; a new change beats a clear
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ua_event <= 1'b0;
            ua_pend <= 1'b0;
        end else begin
            ua_event <= result.done && result.sense_key != `MPS_KEY_ILLEGAL && bcnt_set;
            if (result.done && result.sense_key != `MPS_KEY_ILLEGAL && bcnt_set) begin
                ua_pend <= 1'b1;
            end else if (ua_clr) begin
                ua_pend <= 1'b0;
            end
        end
    end
endmodule

/* File: sim/mps_checker_assertions.sv */
/* port checker of the list checker.
   assumes it is bound onto mps_checker. */
`timescale 1ns/1ps
module mps_checker_assertions #(
    parameter logic [31:0] PHYS_MAX_BLOCKS = 32'h00800000,
    parameter logic [31:0] DEF_BLOCKS = 32'h00400000
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire mps_pkg::mps_axi_req_s axi_req,
    input wire mps_pkg::mps_axi_rsp_s axi_rsp,
    input wire logic dout_valid,
    input wire logic [7:0] dout_data,
    input wire logic dout_ready,
    input wire mps_pkg::mps_result_s result,
    input wire logic save_req,
    input wire logic save_ack,
    input wire logic ua_event
);
    import mps_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    property p_rej; result.done && result.check && !result.rounded
        |-> result.sense_key == 4'h5 && result.asc == 8'h26; endproperty
    a_rej: assert property (p_rej) else $error("bad reject code");
    property p_rnd; result.done && result.check && result.rounded
        |-> result.sense_key == 4'h1 && result.asc == 8'h37; endproperty
    a_rnd: assert property (p_rnd) else $error("bad round code");
    property p_good; result.done && !result.check |-> result.sense_key == 4'h0; endproperty
    a_good: assert property (p_good) else $error("bad good code");
    property p_hold; save_req && !save_ack |=> save_req; endproperty
    a_hold: assert property (p_hold) else $error("save dropped");
    property p_first; save_req |-> !result.done; endproperty
    a_first: assert property (p_first) else $error("done before save");
    property p_fell; $fell(dout_ready) |-> ##[1:2] (result.done || save_req); endproperty
    a_fell: assert property (p_fell) else $error("late answer");
    property p_idle; result.done |-> !dout_ready; endproperty
    a_idle: assert property (p_idle) else $error("done mid list");
    property p_noua; ua_event |-> $past(result.done) && $past(result.sense_key) != 4'h5;
        endproperty
    a_noua: assert property (p_noua) else $error("change on reject");
    c_rej: cover property (result.done && result.check);
    c_rnd: cover property (result.done && result.rounded);
    c_save: cover property (save_req && save_ack);
endmodule
bind mps_checker mps_checker_assertions #(.PHYS_MAX_BLOCKS(PHYS_MAX_BLOCKS),
    .DEF_BLOCKS(DEF_BLOCKS)) u_chk (.clk(clk), .rst_b(rst_b), .axi_req(axi_req),
    .axi_rsp(axi_rsp), .dout_valid(dout_valid), .dout_data(dout_data),
    .dout_ready(dout_ready), .result(result), .save_req(save_req),
    .save_ack(save_ack), .ua_event(ua_event));

/* File: sim/mps_host_model.sv */
/* initiator model: offers queued data-out bytes, stalls while slow.
   assumes the bench fills q and drives slow. */
`timescale 1ns/1ps
module mps_host_model (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic slow,
    input wire logic dout_ready,
    output logic dout_valid,
    output logic [7:0] dout_data
);
    logic [7:0] q[$];
    // byte held until taken; idle line shows the inverse
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            dout_valid <= 1'b0;
            dout_data <= 8'hA5;
        end else if (!dout_valid || dout_ready) begin
            if (dout_valid) q.delete(0);
            dout_valid <= q.size() > 0 && !slow;
            dout_data <= (q.size() > 0 && !slow) ? q[0] : ~dout_data;
        end
    end
endmodule

/* File: sim/mps_checker_bench.sv */
/* self-checking bench of the list checker.
   assumes the design, package and host model are compiled first. */
`timescale 1ns/1ps
`include "mps_defines.svh"
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin errors++; \
    $display("unexpected %s exp %0h got %0h", n, e, s); end end
module mps_checker_bench;
    import mps_pkg::*;
    localparam int LIM = 300;
    logic clk = 0, rst_b = 0, slow = 0, save_ack = 0, dv, dr, sr, ua;
    logic [7:0] dd;
    logic [31:0] st;
    logic [1:0] rr;
    mps_axi_req_s rq = '0;
    mps_axi_rsp_s rs;
    mps_result_s res;
    int errors = 0, samples_checked = 0, seed = 32'hae9c, eb = 'h200, i, b, ue = 0, un = 0;
    always #50 clk = ~clk;
    always @(posedge clk) slow <= 1'($random(seed));
    always @(posedge clk) un += ua;
    mps_checker dut (.clk(clk), .rst_b(rst_b), .axi_req(rq), .axi_rsp(rs), .dout_valid(dv),
        .dout_data(dd), .dout_ready(dr), .result(res), .save_req(sr), .save_ack(save_ack),
        .ua_event(ua));
    mps_host_model mdl (.clk(clk), .rst_b(rst_b), .slow(slow), .dout_ready(dr),
        .dout_valid(dv), .dout_data(dd));
    task tally_and_finish;
        $display("checked %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task tmo(input int n);
        if (n >= LIM) begin
            errors++;
            tally_and_finish();
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        rq.awaddr <= a;
        rq.wdata <= d;
        rq.wstrb <= 4'hF;
        rq.awvalid <= 1'b1;
        rq.wvalid <= 1'b1;
        rq.bready <= 1'b1;
        for (n = 0; n < LIM; n++) begin
            @(posedge clk);
            if (rs.awready && rq.awvalid) rq.awvalid <= 1'b0;
            if (rs.wready && rq.wvalid) rq.wvalid <= 1'b0;
            if (rs.bvalid) break;
        end
        tmo(n);
    endtask
    task rd(input logic [7:0] a);
        int n;
        rq.araddr <= a;
        rq.arvalid <= 1'b1;
        rq.rready <= 1'b1;
        for (n = 0; n < LIM; n++) begin
            @(posedge clk);
            if (rs.arready) rq.arvalid <= 1'b0;
            if (rs.rvalid) break;
        end
        st = rs.rdata;
        rr = rs.rresp;
        tmo(n);
    endtask
    task pb(input logic [7:0] x);
        mdl.q.push_back(x);
    endtask
    task hdr(input logic [7:0] l);
        pb(8'h00);
        pb(8'h00);
        pb(8'h00);
        pb(l);
    endtask
    task desc(input logic [31:0] cnt, input logic [23:0] bl);
        hdr(8'h08);
        for (i = 0; i < 4; i++) pb(cnt[31-8*i -: 8]);
        pb(8'h00);
        for (i = 0; i < 3; i++) pb(bl[23-8*i -: 8]);
    endtask
    task pg(input logic [7:0] code, input logic [7:0] len, input logic [7:0] first);
        pb(code);
        pb(len);
        pb(first);
        for (i = 1; i < len; i++) pb(8'h00);
    endtask
    // one command: expected status and block length from the list sent
    task run(input logic [5:0] c, input logic rej, input int bl);
        int n, r;
        r = (bl > 4096) ? 4096 : (bl < (c[5] ? 256 : 180)) ? (c[5] ? 256 : 180) : bl & ~1;
        wr(`MPS_A_LEN, 32'(mdl.q.size()));
        wr(`MPS_A_CTRL, {26'h0, c} | 32'h1);
        for (n = 0; n < LIM; n++) begin
            @(posedge clk);
            save_ack <= sr;
            if (res.done) break;
        end
        tmo(n);
        mdl.q.delete();
        rd(`MPS_A_STAT);
        `CHK("status", rej ? 12'h265 : (bl != 0 && r != bl && c[2]) ? 12'h371 : 12'h000,
            {st[23:16], st[11:8]})
        if (!rej && bl != 0 && r != eb) ue++;
        `CHK("ua", {ue, ue != 0}, {un, st[3]})
        if (!rej && bl != 0) eb = r;
        rd(`MPS_A_BLEN);
        `CHK("blen", eb, st)
    endtask
    initial begin
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        rd(8'h20);
        `CHK("decerr", 2'h3, rr)
        run(6'h00, 0, 0);
        hdr(8'h00); run(6'h00, 0, 0);
        desc(0, 24'h400); run(6'h08, 0, 'h400);
        hdr(8'h04); run(6'h00, 1, 0);
        desc(0, 24'h65); run(6'h04, 0, 'h65);
        desc(0, 24'h2001); run(6'h00, 0, 'h2001);
        desc(0, 24'h3FF); run(6'h00, 0, 'h3FF);
        desc(0, 24'hC8); run(6'h20, 0, 'hC8);
        hdr(8'h00); pg(8'h01, 8'h08, 8'h00); run(6'h00, 1, 0);
        for (b = 0; b < 2; b++) begin
            hdr(8'h00); pg(8'h02, 8'h0A, 8'h00); run(b ? 6'h02 : 6'h00, b == 1, 0);
            hdr(8'h00); pg(8'h01, 8'h0A, 8'h01); run(b ? 6'h02 : 6'h00, b == 1, 0);
        end
        desc(32'h00900000, 24'h200); run(6'h10, 1, 0);
        desc(32'h00000001, 24'h200); run(6'h00, 1, 0);
        desc(32'hFFFFFFFF, 24'h200); run(6'h10, 0, 'h200);
        rd(`MPS_A_BCNT);
        `CHK("bcnt", 32'h00400000, st)
        repeat (4) begin
            b = 180 + 2 * ($unsigned($random(seed)) % 1959);
            desc(0, b[23:0]); run(6'h00, 0, b);
        end
        tally_and_finish();
    end
endmodule
